// file: timer_pair_defs.svh
// register map, field positions and reset values of the timer pair
// What this block does
// - each main timer: 16-bit count, two bytes
// - modes set independently: four on timer a, three on timer b
// - 13-bit, 16-bit, 8-bit reload, split
// - five clock sources via select and scale
// - timer clock: system clock or prescaled
// - counter mode counts falling event-pin edges
// - events up to quarter clock rate counted
// - 13-bit: high byte msbs, low bits 4..0
// - 13-bit wrap sets flag, irq if enabled
// - run bit enables, gate qualifies by input
// - run clear or gate inactive stops timer
// - gate active level from polarity bit
// - setting run keeps the count value
// - timer b mirrors timer a, own controls, no split
// - irq enables in global register: one per main timer, one shared by the aux timers
// - aux timers: 16-bit or split, reload
// - aux clock: system, /12, external /8
// - aux timer d runs in suspend on external /8, wakes
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH

`define ADDR_TIMER_CONTROL   8'h00
`define ADDR_TIMER_MODE      8'h01
`define ADDR_CLOCK_CONTROL   8'h02
`define ADDR_TIMER_A_LOW     8'h03
`define ADDR_TIMER_A_HIGH    8'h04
`define ADDR_TIMER_B_LOW     8'h05
`define ADDR_TIMER_B_HIGH    8'h06
`define ADDR_EXT_IRQ_CONFIG  8'h07
`define ADDR_GLOBAL_IRQ_EN   8'h08
// auxiliary timers occupy eight addresses each
`define ADDR_AUX_C_BASE      5'h02
`define ADDR_AUX_D_BASE      5'h03
`define AUX_OFS_CTRL         3'h0
`define AUX_OFS_RELOAD_LOW   3'h1
`define AUX_OFS_RELOAD_HIGH  3'h2
`define AUX_OFS_COUNT_LOW    3'h3
`define AUX_OFS_COUNT_HIGH   3'h4

// timer_control_reg fields
`define TCTRL_RUN_A          4
`define TCTRL_FLAG_A         5
`define TCTRL_RUN_B          6
`define TCTRL_FLAG_B         7
// timer_mode_reg fields
`define TMODE_COUNTER_A      2
`define TMODE_GATE_A         3
`define TMODE_COUNTER_B      6
`define TMODE_GATE_B         7
// clock_control_reg fields
`define CKCTRL_CLKSEL_A      2
`define CKCTRL_CLKSEL_B      3
// ext_irq_config_reg fields
`define EXTCFG_POL_A         3
`define EXTCFG_POL_B         7
// global_irq_enable_reg fields
`define IRQEN_TIMER_A        1
`define IRQEN_TIMER_B        3
`define IRQEN_AUX            5
// aux control fields
`define AUXCTRL_RUN          0
`define AUXCTRL_SPLIT        1
`define AUXCTRL_FLAG_LOW     6
`define AUXCTRL_FLAG_HIGH    7

`define RESET_BYTE           8'h00
// prescaler: one count of 48 yields /4, /12 and /48
`define PRESCALE_LAST        6'd47
`define EXT_DIV_LAST         3'h7

`endif

// file: timer_pair_pkg.sv
// types shared by the timer pair modules
package timer_pair_pkg;

	typedef enum logic [1:0] {
		MODE_13BIT       = 2'h0,
		MODE_16BIT       = 2'h1,
		MODE_8BIT_RELOAD = 2'h2,
		MODE_SPLIT       = 2'h3
	} timer_mode_t;

	typedef enum logic [1:0] {
		SCALE_DIV12 = 2'h0,
		SCALE_DIV4  = 2'h1,
		SCALE_DIV48 = 2'h2,
		SCALE_EXT8  = 2'h3
	} clock_scale_t;

	typedef enum logic [1:0] {
		AUX_CLK_SYS   = 2'h0,
		AUX_CLK_DIV12 = 2'h1,
		AUX_CLK_EXT8  = 2'h2
	} aux_clock_t;

endpackage : timer_pair_pkg

// file: timer_ch_if.sv
// signals between the top and one main timer channel
`timescale 1ns/1ps
interface timer_ch_if;
	logic                      tick_low;
	logic                      tick_high;
	logic                      wr_low;
	logic                      wr_high;
	logic [7:0]                wdata;
	timer_pair_pkg::timer_mode_t mode;
	logic [7:0]                count_low;
	logic [7:0]                count_high;
	logic                      ovf_low;
	logic                      ovf_high;

	modport ctrl (output tick_low, tick_high, wr_low, wr_high, wdata, mode,
		input count_low, count_high, ovf_low, ovf_high);
	modport chan (input tick_low, tick_high, wr_low, wr_high, wdata, mode,
		output count_low, count_high, ovf_low, ovf_high);
endinterface : timer_ch_if

// file: main_timer_channel.sv
// one main counter/timer: byte pair and four counting modes
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module main_timer_channel #(
	parameter bit SPLIT_OK = 1'b0
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	timer_ch_if.chan  ch
);
	logic [7:0]  count_low;
	logic [7:0]  count_high;
	logic [7:0]  next_low;
	logic [7:0]  next_high;
	logic [12:0] inc13;
	logic [15:0] inc16;
	logic        ovf_low;
	logic        ovf_high;

	assign inc13 = {count_high, count_low[4:0]} + 13'h0001;
	assign inc16 = {count_high, count_low} + 16'h0001;

	// next count per mode; a byte write beats the increment
	always_comb begin
		next_low  = count_low;
		next_high = count_high;
		ovf_low   = 1'b0;
		ovf_high  = 1'b0;
		if (ch.tick_low) begin
			unique case (ch.mode)
				timer_pair_pkg::MODE_13BIT: begin
					next_low  = {count_low[7:5], inc13[4:0]};
					next_high = inc13[12:5];
					ovf_low   = ({count_high, count_low[4:0]} == 13'h1fff);
				end
				timer_pair_pkg::MODE_16BIT: begin
					next_low  = inc16[7:0];
					next_high = inc16[15:8];
					ovf_low   = ({count_high, count_low} == 16'hffff);
				end
				timer_pair_pkg::MODE_8BIT_RELOAD: begin
					next_low = (count_low == 8'hff) ? count_high : count_low + 8'h01;
					ovf_low  = (count_low == 8'hff);
				end
				timer_pair_pkg::MODE_SPLIT: begin
					// without split support the timer simply holds
					if (SPLIT_OK) begin
						next_low = count_low + 8'h01;
						ovf_low  = (count_low == 8'hff);
					end
				end
			endcase
		end
		if (SPLIT_OK && ch.mode == timer_pair_pkg::MODE_SPLIT && ch.tick_high) begin
			next_high = count_high + 8'h01;
			ovf_high  = (count_high == 8'hff);
		end
		if (ch.wr_low) begin
			next_low = ch.wdata;
		end
		if (ch.wr_high) begin
			next_high = ch.wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_low  <= `RESET_BYTE;
			count_high <= `RESET_BYTE;
		end else begin
			count_low  <= next_low;
			count_high <= next_high;
		end
	end

	assign ch.count_low  = count_low;
	assign ch.count_high = count_high;
	assign ch.ovf_low    = ovf_low;
	assign ch.ovf_high   = ovf_high;
endmodule : main_timer_channel

// file: timer_pair.sv
// top: two main counter/timers and two auto-reload auxiliary timers
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module timer_pair (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       event_pin_a,
	input  wire logic       event_pin_b,
	input  wire logic       gate_input_a,
	input  wire logic       gate_input_b,
	input  wire logic       ext_osc_pin,
	input  wire logic       suspend_req,
	output logic            irq_timer_a,
	output logic            irq_timer_b,
	output logic            irq_aux,
	output logic            wake_req
);
	// software-visible control state
	logic       run_a;
	logic       run_b;
	logic       flag_a;
	logic       flag_b;
	logic [7:0] timer_mode_reg;
	logic [3:0] clock_control_reg;
	logic       gate_a_polarity;
	logic       gate_b_polarity;
	logic       timer_a_irq_enable;
	logic       timer_b_irq_enable;
	logic       aux_irq_enable;

	// pin synchronisers: {osc, gate b, gate a, event b, event a}
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic [4:0] pin_last;

	// prescaler state
	logic [5:0] prescale_cnt;
	logic [2:0] ext_div_cnt;

	timer_ch_if ch_a ();
	timer_ch_if ch_b ();

	// address decode
	// no wait states: each access completes at the edge that sees its strobe
	wire wr_tctrl  = reg_wr && reg_addr == `ADDR_TIMER_CONTROL;
	wire wr_tmode  = reg_wr && reg_addr == `ADDR_TIMER_MODE;
	wire wr_ckctrl = reg_wr && reg_addr == `ADDR_CLOCK_CONTROL;
	wire wr_extcfg = reg_wr && reg_addr == `ADDR_EXT_IRQ_CONFIG;
	wire wr_irqen  = reg_wr && reg_addr == `ADDR_GLOBAL_IRQ_EN;

	// field views
	wire timer_a_counter_select = timer_mode_reg[`TMODE_COUNTER_A];
	wire timer_a_gate_enable    = timer_mode_reg[`TMODE_GATE_A];
	wire timer_b_counter_select = timer_mode_reg[`TMODE_COUNTER_B];
	wire timer_b_gate_enable    = timer_mode_reg[`TMODE_GATE_B];
	wire timer_a_clock_select   = clock_control_reg[`CKCTRL_CLKSEL_A];
	wire timer_b_clock_select   = clock_control_reg[`CKCTRL_CLKSEL_B];
	wire [1:0] clock_scale_field = clock_control_reg[1:0];

	// all five pins are outside the clock domain; only pin_sync reads pin_meta
	// reset value sits below the event idle level, so release shows a rise, never a fall
	// two-flop capture
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= 5'h00;
			pin_sync <= 5'h00;
			pin_last <= 5'h00;
		end else begin
			pin_meta <= {ext_osc_pin, gate_input_b, gate_input_a, event_pin_b, event_pin_a};
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	// falling-edge detect on events, rising on the oscillator
	// the edge flop adds a cycle; counts land three edges after the pin
	wire fall_a   = pin_last[0] && !pin_sync[0];
	wire fall_b   = pin_last[1] && !pin_sync[1];
	wire osc_rise = pin_sync[4] && !pin_last[4];

	// one free-running count of 48 gives all three dividers in phase
	// oscillator divider phase after reset is arbitrary; only its rate matters
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale_cnt <= 6'h00;
			ext_div_cnt  <= 3'h0;
		end else begin
			prescale_cnt <= (prescale_cnt == `PRESCALE_LAST) ? 6'h00 : prescale_cnt + 6'h01;
			if (osc_rise) begin
				ext_div_cnt <= ext_div_cnt + 3'h1;
			end
		end
	end

	wire tick_div4  = prescale_cnt[1:0] == 2'h3;
	wire tick_div12 = prescale_cnt == 6'd11 || prescale_cnt == 6'd23 ||
		prescale_cnt == 6'd35 || prescale_cnt == 6'd47;
	wire tick_div48 = prescale_cnt == `PRESCALE_LAST;
	wire tick_ext8  = osc_rise && ext_div_cnt == `EXT_DIV_LAST;

	// scale code 0 (/12) is the reset choice, so a fresh timer runs slow
	// scaled clock choice
	wire tick_scaled =
		(clock_scale_field == timer_pair_pkg::SCALE_DIV12) ? tick_div12 :
		(clock_scale_field == timer_pair_pkg::SCALE_DIV4)  ? tick_div4  :
		(clock_scale_field == timer_pair_pkg::SCALE_DIV48) ? tick_div48 : tick_ext8;

	wire time_tick_a = timer_a_clock_select ? 1'b1 : tick_scaled;
	wire time_tick_b = timer_b_clock_select ? 1'b1 : tick_scaled;

	wire src_a = timer_a_counter_select ? fall_a : time_tick_a;
	wire src_b = timer_b_counter_select ? fall_b : time_tick_b;

	wire gate_a_active = pin_sync[2] == gate_a_polarity;
	wire gate_b_active = pin_sync[3] == gate_b_polarity;

	// suspend overrides run so a sleeping core sees frozen counts
	// run and gate
	wire enable_a = run_a && (!timer_a_gate_enable || gate_a_active) && !suspend_req;
	wire enable_b = run_b && (!timer_b_gate_enable || gate_b_active) && !suspend_req;

	assign ch_a.mode = timer_pair_pkg::timer_mode_t'(timer_mode_reg[1:0]);
	assign ch_b.mode = timer_pair_pkg::timer_mode_t'(timer_mode_reg[5:4]);

	// byte writes reach the channels unstaged, so a write and a tick can meet
	// twin channel hookup
	assign ch_a.tick_low  = enable_a && src_a;
	assign ch_b.tick_low  = enable_b && src_b;
	// split high half of timer a borrows run b and the timer clock of a
	assign ch_a.tick_high = run_b && time_tick_a && !suspend_req;
	assign ch_b.tick_high = 1'b0;
	assign ch_a.wr_low    = reg_wr && reg_addr == `ADDR_TIMER_A_LOW;
	assign ch_a.wr_high   = reg_wr && reg_addr == `ADDR_TIMER_A_HIGH;
	assign ch_b.wr_low    = reg_wr && reg_addr == `ADDR_TIMER_B_LOW;
	assign ch_b.wr_high   = reg_wr && reg_addr == `ADDR_TIMER_B_HIGH;
	assign ch_a.wdata     = reg_wdata;
	assign ch_b.wdata     = reg_wdata;

	main_timer_channel #(.SPLIT_OK(1'b1)) timer_a_chan (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.ch       (ch_a)
	);

	main_timer_channel #(.SPLIT_OK(1'b0)) timer_b_chan (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.ch       (ch_b)
	);

	// a clear written in the overflow cycle is lost; software re-reads the flag
	// set beats clear
	wire next_flag_a = ch_a.ovf_low ||
		(wr_tctrl ? reg_wdata[`TCTRL_FLAG_A] : flag_a);
	wire next_flag_b = ch_b.ovf_low || ch_a.ovf_high ||
		(wr_tctrl ? reg_wdata[`TCTRL_FLAG_B] : flag_b);

	// control registers; run changes never touch the count
	// only software writes these; hardware owns just the two flags
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_a              <= 1'b0;
			run_b              <= 1'b0;
			flag_a             <= 1'b0;
			flag_b             <= 1'b0;
			timer_mode_reg     <= `RESET_BYTE;
			clock_control_reg  <= 4'h0;
			gate_a_polarity    <= 1'b0;
			gate_b_polarity    <= 1'b0;
			timer_a_irq_enable <= 1'b0;
			timer_b_irq_enable <= 1'b0;
			aux_irq_enable     <= 1'b0;
		end else begin
			flag_a <= next_flag_a;
			flag_b <= next_flag_b;
			if (wr_tctrl) begin
				run_a <= reg_wdata[`TCTRL_RUN_A];
				run_b <= reg_wdata[`TCTRL_RUN_B];
			end
			if (wr_tmode) begin
				timer_mode_reg <= reg_wdata;
			end
			if (wr_ckctrl) begin
				clock_control_reg <= reg_wdata[3:0];
			end
			if (wr_extcfg) begin
				gate_a_polarity <= reg_wdata[`EXTCFG_POL_A];
				gate_b_polarity <= reg_wdata[`EXTCFG_POL_B];
			end
			if (wr_irqen) begin
				timer_a_irq_enable <= reg_wdata[`IRQEN_TIMER_A];
				timer_b_irq_enable <= reg_wdata[`IRQEN_TIMER_B];
				aux_irq_enable     <= reg_wdata[`IRQEN_AUX];
			end
		end
	end

	// auxiliary timers: c is index 0, d is index 1
	// each aux timer owns an eight-address window; offsets 5..7 read zero
	wire [7:0] aux_rd    [2];
	wire       aux_hit   [2];
	wire       aux_flags [2];
	wire       aux_wrap  [2];

	for (genvar i = 0; i < 2; i++) begin : g_aux
		logic [7:0]  ctrl;
		logic [15:0] reload;
		logic [15:0] count;
		logic [15:0] next_count;
		logic        wrap_low;
		logic        wrap_high;
		logic        tick;

		wire [4:0] base = (i == 0) ? `ADDR_AUX_C_BASE : `ADDR_AUX_D_BASE;
		wire       hit  = reg_addr[7:3] == base;
		wire [2:0] ofs  = reg_addr[2:0];
		wire       wr   = reg_wr && hit;
		wire [1:0] sel  = ctrl[3:2];
		wire       split = ctrl[`AUXCTRL_SPLIT];

		wire src_tick =
			(sel == timer_pair_pkg::AUX_CLK_SYS)   ? 1'b1 :
			(sel == timer_pair_pkg::AUX_CLK_DIV12) ? tick_div12 :
			(sel == timer_pair_pkg::AUX_CLK_EXT8)  ? tick_ext8 : 1'b0;
		// aux c has no suspend path; it always stops with the core
		// d runs in suspend on the external /8 clock
		wire may_run = !suspend_req ||
			(i == 1 && sel == timer_pair_pkg::AUX_CLK_EXT8);
		assign tick = ctrl[`AUXCTRL_RUN] && src_tick && may_run;

		always_comb begin
			next_count = count;
			wrap_low   = 1'b0;
			wrap_high  = 1'b0;
			if (tick && split) begin
				wrap_low  = count[7:0] == 8'hff;
				wrap_high = count[15:8] == 8'hff;
				next_count[7:0]  = wrap_low  ? reload[7:0]  : count[7:0] + 8'h01;
				next_count[15:8] = wrap_high ? reload[15:8] : count[15:8] + 8'h01;
			end else if (tick) begin
				wrap_high  = count == 16'hffff;
				next_count = wrap_high ? reload : count + 16'h0001;
			end
			if (wr && ofs == `AUX_OFS_COUNT_LOW) begin
				next_count[7:0] = reg_wdata;
			end
			if (wr && ofs == `AUX_OFS_COUNT_HIGH) begin
				next_count[15:8] = reg_wdata;
			end
		end

		// aux registers; a write of the flags loses to a fresh wrap
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				ctrl   <= `RESET_BYTE;
				reload <= 16'h0000;
				count  <= 16'h0000;
			end else begin
				count <= next_count;
				if (wr && ofs == `AUX_OFS_CTRL) begin
					ctrl <= reg_wdata;
				end
				ctrl[`AUXCTRL_FLAG_LOW] <= wrap_low ||
					((wr && ofs == `AUX_OFS_CTRL) ? reg_wdata[`AUXCTRL_FLAG_LOW] : ctrl[`AUXCTRL_FLAG_LOW]);
				ctrl[`AUXCTRL_FLAG_HIGH] <= wrap_high ||
					((wr && ofs == `AUX_OFS_CTRL) ? reg_wdata[`AUXCTRL_FLAG_HIGH] : ctrl[`AUXCTRL_FLAG_HIGH]);
				if (wr && ofs == `AUX_OFS_RELOAD_LOW) begin
					reload[7:0] <= reg_wdata;
				end
				if (wr && ofs == `AUX_OFS_RELOAD_HIGH) begin
					reload[15:8] <= reg_wdata;
				end
			end
		end

		assign aux_hit[i]   = hit && ofs <= `AUX_OFS_COUNT_HIGH;
		assign aux_flags[i] = ctrl[`AUXCTRL_FLAG_LOW] || ctrl[`AUXCTRL_FLAG_HIGH];
		assign aux_wrap[i]  = wrap_low || wrap_high;
		assign aux_rd[i] =
			(ofs == `AUX_OFS_CTRL)        ? ctrl :
			(ofs == `AUX_OFS_RELOAD_LOW)  ? reload[7:0] :
			(ofs == `AUX_OFS_RELOAD_HIGH) ? reload[15:8] :
			(ofs == `AUX_OFS_COUNT_LOW)   ? count[7:0] :
			(ofs == `AUX_OFS_COUNT_HIGH)  ? count[15:8] : 8'h00;
	end

	// read view of the control register; bits 3..0 unused here
	wire [7:0] tctrl_view = {flag_b, run_b, flag_a, run_a, 4'h0};

	// read selection; unmapped addresses read zero
	// zero outside the read cycle lets several slaves share an or-ed bus
	wire [7:0] rd_mux =
		(reg_addr == `ADDR_TIMER_CONTROL)  ? tctrl_view :
		(reg_addr == `ADDR_TIMER_MODE)     ? timer_mode_reg :
		(reg_addr == `ADDR_CLOCK_CONTROL)  ? {4'h0, clock_control_reg} :
		(reg_addr == `ADDR_TIMER_A_LOW)    ? ch_a.count_low :
		(reg_addr == `ADDR_TIMER_A_HIGH)   ? ch_a.count_high :
		(reg_addr == `ADDR_TIMER_B_LOW)    ? ch_b.count_low :
		(reg_addr == `ADDR_TIMER_B_HIGH)   ? ch_b.count_high :
		(reg_addr == `ADDR_EXT_IRQ_CONFIG) ? {gate_b_polarity, 3'h0, gate_a_polarity, 3'h0} :
		(reg_addr == `ADDR_GLOBAL_IRQ_EN)  ?
			{2'h0, aux_irq_enable, 1'b0, timer_b_irq_enable, 1'b0, timer_a_irq_enable, 1'b0} :
		aux_hit[0] ? aux_rd[0] :
		aux_hit[1] ? aux_rd[1] : 8'h00;

	// outputs straight from flops; data valid only the cycle after a read
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata   <= 8'h00;
			irq_timer_a <= 1'b0;
			irq_timer_b <= 1'b0;
			irq_aux     <= 1'b0;
			wake_req    <= 1'b0;
		end else begin
			reg_rdata   <= reg_rd ? rd_mux : 8'h00;
			// timer irqs use the next flag, so they rise with it, not a cycle late
			// flag raises irq
			irq_timer_a <= next_flag_a && timer_a_irq_enable;
			irq_timer_b <= next_flag_b && timer_b_irq_enable;
			irq_aux     <= (aux_flags[0] || aux_flags[1]) && aux_irq_enable;
			wake_req    <= suspend_req && (aux_wrap[1] || (wake_req && suspend_req));
		end
	end
endmodule : timer_pair

// file: timer_pair_checker.sv
// port-level assertion checker for the timer pair, bound to the top
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module timer_pair_checker (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       suspend_req,
	input wire logic       irq_timer_a,
	input wire logic       irq_timer_b,
	input wire logic       wake_req
);
	logic [7:0] mode_sh;
	logic       run_a_sh;
	logic       run_b_sh;
	logic       en_a_sh;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// shadow of bits only software writes, so reads can be predicted
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_sh  <= 8'h00;
			run_a_sh <= 1'b0;
			run_b_sh <= 1'b0;
			en_a_sh  <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == `ADDR_TIMER_MODE) mode_sh <= reg_wdata;
			if (reg_addr == `ADDR_TIMER_CONTROL) {run_b_sh, run_a_sh} <= {reg_wdata[6], reg_wdata[4]};
			if (reg_addr == `ADDR_GLOBAL_IRQ_EN) en_a_sh <= reg_wdata[1];
		end
	end

	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
	property p_unmapped;
		$past(reg_rd) && $past(reg_addr) >= 8'h20 |-> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_mode_rb;
		$past(reg_rd) && $past(reg_addr) == `ADDR_TIMER_MODE |-> reg_rdata == $past(mode_sh);
	endproperty
	a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
	property p_ctrl_rb;
		$past(reg_rd) && $past(reg_addr) == `ADDR_TIMER_CONTROL
			|-> reg_rdata[3:0] == 4'h0 && reg_rdata[4] == $past(run_a_sh) && reg_rdata[6] == $past(run_b_sh);
	endproperty
	a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
	property p_irq_off;
		!$past(en_a_sh) |-> !irq_timer_a;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("timer a irq while disabled");
	property p_irq_sticky;
		$past(irq_timer_a) && !$past(reg_wr) && !$past(reg_wr, 2) |-> irq_timer_a;
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("timer a irq dropped alone");
	property p_wake_cause;
		wake_req |-> $past(suspend_req);
	endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake without suspend");
	property p_wake_held;
		$past(wake_req) && $past(suspend_req) |-> wake_req;
	endproperty
	a_wake_held: assert property (p_wake_held) else $error("wake dropped in suspend");

	c_irq_a: cover property ($rose(irq_timer_a));
	c_irq_b: cover property ($rose(irq_timer_b));
	c_wake: cover property ($rose(wake_req));
endmodule : timer_pair_checker

bind timer_pair timer_pair_checker timer_pair_checker_inst (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .suspend_req, .irq_timer_a, .irq_timer_b, .wake_req);

// file: event_source_model.sv
// far-side pins: event sources, gate levels and a free-running oscillator
`timescale 1ns/1ps
module event_source_model (
	input  wire logic core_clk,
	output logic      event_pin_a,
	output logic      event_pin_b,
	output logic      gate_input_a,
	output logic      gate_input_b,
	output logic      ext_osc_pin
);
	logic [1:0] osc_cnt;

	initial begin
		event_pin_a = 1'b1;
		event_pin_b = 1'b1;
		gate_input_a = 1'b0;
		gate_input_b = 1'b0;
		ext_osc_pin = 1'b0;
		osc_cnt = 2'h0;
	end

	// oscillator never stops, one rising edge every four clocks
	always @(posedge core_clk) begin
		osc_cnt <= osc_cnt + 2'h1;
		ext_osc_pin <= osc_cnt[1];
	end

	// falling edges; two-clock holds reach the quarter-rate limit
	// level hold two or three clocks
	task automatic falls(input bit pin_b, input int n);
		int hold;
		for (int i = 0; i < n; i++) begin
			hold = 2 + ($urandom % 2);
			if (pin_b) event_pin_b <= 1'b0;
			else event_pin_a <= 1'b0;
			repeat (hold) @(posedge core_clk);
			if (pin_b) event_pin_b <= 1'b1;
			else event_pin_a <= 1'b1;
			repeat (hold) @(posedge core_clk);
		end
	endtask : falls

	// gate pins are plain levels
	task automatic set_gate(input bit pin_b, input logic lvl);
		if (pin_b) gate_input_b <= lvl;
		else gate_input_a <= lvl;
	endtask : set_gate
endmodule : event_source_model

// file: test_timer_pair.sv
// self-checking bench for the timer pair
`timescale 1ns/1ps
`include "timer_pair_defs.svh"
module test_timer_pair;
	logic        core_clk, rst_b, reg_wr, reg_rd, rd_pend, suspend_req;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
	logic        event_pin_a, event_pin_b, gate_input_a, gate_input_b, ext_osc_pin;
	logic        irq_timer_a, irq_timer_b, irq_aux, wake_req;
	logic [15:0] exp_q[$];
	logic [15:0] ent;
	int          fails, tests_run;

	timer_pair timer_pair_inst (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.event_pin_a, .event_pin_b, .gate_input_a, .gate_input_b, .ext_osc_pin, .suspend_req,
		.irq_timer_a, .irq_timer_b, .irq_aux, .wake_req);
	event_source_model event_source_model_inst (.core_clk, .event_pin_a, .event_pin_b, .gate_input_a,
		.gate_input_b, .ext_osc_pin);

	always #12.5 core_clk = ~core_clk;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// read data stands only in the cycle after the strobe; oldest note first
	always @(posedge core_clk) rd_pend <= reg_rd;
	always @(negedge core_clk) begin
		if (rd_pend === 1'b1 && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			check(reg_rdata & ent[15:8], ent[7:0]);
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		exp_q.push_back({m, e & m});
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask : rd

	// events land three clocks after the pin edge
	task automatic ev(input bit b, input int n);
		repeat (3) @(posedge core_clk);
		event_source_model_inst.falls(b, n);
		repeat (4) @(posedge core_clk);
	endtask : ev

	task automatic wait_hi(input bit wake, input int limit);
		int n;
		n = 0;
		while ((wake ? wake_req : irq_timer_a) !== 1'b1) begin
			@(posedge core_clk);
			n++;
			if (n > limit) begin
				fails++;
				$display("MISMATCH at %0t: wait ran out", $time);
				final_report();
			end
		end
		@(negedge core_clk);
	endtask : wait_hi

	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		suspend_req = 1'b0;
		fails = 0;
		tests_run = 0;
		void'($urandom(31208));
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		// reset contents, then a write and read to a hole in the map
		for (int a = 0; a <= 8; a++) rd(8'(a), 8'hff, `RESET_BYTE);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'hff, 8'h00);
		$display("reset test done");
		// every mode code on both timers, other bits random
		for (int m = 0; m < 4; m++) begin
			v = 8'($urandom);
			v[1:0] = 2'(m);
			v[5:4] = 2'(3 - m);
			wr(`ADDR_TIMER_MODE, v);
			rd(`ADDR_TIMER_MODE, 8'hff, v);
		end
		$display("mode test done");
		// timer b 13-bit event counting: carry from bit 4 into the high byte
		// count loaded before run is set
		wr(`ADDR_TIMER_MODE, 8'h40);
		wr(`ADDR_TIMER_B_LOW, 8'h1d);
		wr(`ADDR_TIMER_B_HIGH, 8'h02);
		wr(`ADDR_TIMER_CONTROL, 8'h40);
		ev(1, 5);
		rd(`ADDR_TIMER_B_LOW, 8'h1f, 8'h02);
		rd(`ADDR_TIMER_B_HIGH, 8'hff, 8'h03);
		// gating with both polarities
		wr(`ADDR_TIMER_MODE, 8'hc0);
		wr(`ADDR_EXT_IRQ_CONFIG, 8'h80);
		ev(1, 3);
		rd(`ADDR_TIMER_B_LOW, 8'h1f, 8'h02);
		event_source_model_inst.set_gate(1, 1'b1);
		ev(1, 3);
		rd(`ADDR_TIMER_B_LOW, 8'h1f, 8'h05);
		wr(`ADDR_EXT_IRQ_CONFIG, 8'h00);
		ev(1, 2);
		rd(`ADDR_TIMER_B_LOW, 8'h1f, 8'h05);
		event_source_model_inst.set_gate(1, 1'b0);
		ev(1, 2);
		rd(`ADDR_TIMER_B_LOW, 8'h1f, 8'h07);
		wr(`ADDR_TIMER_CONTROL, 8'h00);
		ev(1, 2);
		rd(`ADDR_TIMER_B_LOW, 8'h1f, 8'h07);
		wr(`ADDR_TIMER_CONTROL, 8'h40);
		ev(1, 1);
		rd(`ADDR_TIMER_B_LOW, 8'h1f, 8'h08);
		// timer b 13-bit wrap raises its own interrupt
		wr(`ADDR_GLOBAL_IRQ_EN, 8'h08);
		wr(`ADDR_TIMER_B_LOW, 8'h1f);
		wr(`ADDR_TIMER_B_HIGH, 8'hff);
		ev(1, 1);
		@(negedge core_clk);
		check({7'h00, irq_timer_b}, 8'h01);
		rd(`ADDR_TIMER_CONTROL, 8'hff, 8'hc0);
		rd(`ADDR_TIMER_B_HIGH, 8'hff, 8'h00);
		wr(`ADDR_TIMER_CONTROL, 8'h40);
		$display("gate test done");
		// timer a 16-bit wrap: sticky flag, interrupt follows its enable
		wr(`ADDR_TIMER_MODE, 8'h05);
		wr(`ADDR_GLOBAL_IRQ_EN, 8'h02);
		wr(`ADDR_TIMER_A_LOW, 8'hfd);
		wr(`ADDR_TIMER_A_HIGH, 8'hff);
		wr(`ADDR_TIMER_CONTROL, 8'h10);
		ev(0, 3);
		wait_hi(0, 20);
		check({7'h00, irq_timer_a}, 8'h01);
		rd(`ADDR_TIMER_CONTROL, 8'hff, 8'h30);
		rd(`ADDR_TIMER_A_HIGH, 8'hff, 8'h00);
		wr(`ADDR_GLOBAL_IRQ_EN, 8'h00);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		check({7'h00, irq_timer_a}, 8'h00);
		rd(`ADDR_TIMER_CONTROL, 8'hff, 8'h30);
		wr(`ADDR_TIMER_CONTROL, 8'h00);
		$display("overflow test done");
		// system clock source: forty clocks between run and stop
		wr(`ADDR_TIMER_MODE, 8'h01);
		wr(`ADDR_TIMER_A_LOW, 8'h00);
		wr(`ADDR_CLOCK_CONTROL, 8'h04);
		wr(`ADDR_TIMER_CONTROL, 8'h10);
		repeat (38) @(posedge core_clk);
		wr(`ADDR_TIMER_CONTROL, 8'h00);
		rd(`ADDR_TIMER_A_LOW, 8'hff, 8'h28);
		// prescaled /4: forty clocks give ten counts whatever the phase
		wr(`ADDR_TIMER_A_LOW, 8'h00);
		wr(`ADDR_CLOCK_CONTROL, 8'h01);
		wr(`ADDR_TIMER_CONTROL, 8'h10);
		repeat (38) @(posedge core_clk);
		wr(`ADDR_TIMER_CONTROL, 8'h00);
		rd(`ADDR_TIMER_A_LOW, 8'hff, 8'h0a);
		$display("clock test done");
		// aux d on the oscillator wraps during suspend and reloads
		wr(8'h19, 8'h34);
		wr(8'h1a, 8'h12);
		wr(8'h1b, 8'hff);
		wr(8'h1c, 8'hff);
		wr(`ADDR_GLOBAL_IRQ_EN, 8'h20);
		suspend_req <= 1'b1;
		wr(8'h18, 8'h09);
		wait_hi(1, 400);
		check({7'h00, wake_req}, 8'h01);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		check({7'h00, irq_aux}, 8'h01);
		wr(8'h18, 8'h80);
		rd(8'h1c, 8'hff, 8'h12);
		suspend_req <= 1'b0;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		check({7'h00, wake_req}, 8'h00);
		$display("suspend test done");
		repeat (4) @(posedge core_clk);
		final_report();
	end
endmodule : test_timer_pair
